// File: inc/adc_consts.svh
// timing counts, widths and depths of the dual converter serial readout
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH
`define RES_W 14
`define FRAME_W 32
`define EDGE_CNT_W 6
`define EDGE_PD_LO 6'h02
`define EDGE_PD_HI 6'h0a
`define EDGE_CONV 6'h10
`define EDGE_LAST 6'h20
`define FIFO_W 28
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define MODE_RESET 3'h1
`endif

// File: inc/adc_pkg.sv
// types shared by the serial readout design
package adc_pkg;
  `include "adc_consts.svh"

  typedef enum logic [2:0] {
    pm_normal = 3'b001,
    pm_partial = 3'b010,
    pm_full = 3'b100
  } power_mode_t;

  typedef struct packed {
    logic [`RES_W-1:0] chan_a;
    logic [`RES_W-1:0] chan_b;
  } result_pair_t;
endpackage : adc_pkg

// File: hw/dual_adc_serial_readout.sv
// serial readout of a dual simultaneous-sampling converter, with its result fifo

module result_fifo #(
  parameter int W = 28,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk, // core clock
  input wire logic rst, // async reset, high
  input wire logic [W-1:0] in_data, // word to store
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  output logic [W-1:0] out_data, // oldest word
  output logic out_valid, // a word is held
  input wire logic out_ready // drain takes it
);
  timeunit 1ns;
  timeprecision 1ps;
  // storage array; one extra pointer bit per side
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  // ready and valid are plain decodes of the pointers, so a push and a
  // pop in one cycle both take effect; the core never offers more than
  // one word per frame, so depth only matters if the drain stalls
  // extra pointer bit tells full from empty
  assign in_ready = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) ||
                    (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset; only pointers need a defined start
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : result_fifo

module dual_adc_serial_readout
  import adc_pkg::*;
(
  input wire logic ref_clk, // core clock, 125 MHz
  input wire logic rst, // async reset, high
  input wire logic [`RES_W-1:0] ain_a, // channel A input level, core clock
  input wire logic [`RES_W-1:0] ain_b, // channel B input level, core clock
  input wire logic sclk, // serial clock from host, link domain
  input wire logic select_n, // frame select from host, low active
  output logic result_line_a, // serial data A
  output logic result_line_a_oe, // A driven
  output logic result_line_b, // serial data B
  output logic result_line_b_oe, // B driven
  output logic sampler_track, // 1 tracking, 0 holding
  output logic sample_strobe, // one pulse per frame start
  output power_mode_t power_mode, // present power state
  output logic fifo_full // results waiting at capacity
);
  timeunit 1ns;
  timeprecision 1ps;
  // frame layout on each line, one bit per falling serial clock edge:
  // select fall shows the first zero, edge 1 the second zero,
  // edges 2 to 15 the own channel msb first, edges 16 and 17 two zeros,
  // edges 18 to 31 the other channel, edge 32 releases the line
  // crossing scheme, chosen over a dual-clock fifo to keep the link small:
  // milestones of the frame leave the link as toggles, which need no
  // handshake back and survive the async clear that select rise applies
  // the published word is quasi-static: the core only changes it while
  // select has been high for two core clocks, and the link only reads it
  // at the first falling edge, well after the frame has opened
  // limitation: a host that puts the first falling edge within about
  // three core clocks of select fall may read a word still settling

  // link domain, falling serial clock edges except the return to track, which uses the rising edge
  logic [`EDGE_CNT_W-1:0] edge_cnt_reg;
  logic [`FRAME_W-1:0] shift_a_reg;
  logic [`FRAME_W-1:0] shift_b_reg;
  logic link_rst;
  logic tog_lo_reg;
  logic tog_hi_reg;
  logic tog_conv_reg;
  logic back_track_reg;
  result_pair_t pub_reg;
  logic [`FRAME_W-1:0] word_a;
  logic [`FRAME_W-1:0] word_b;

  // a raised select clears the frame at once, without waiting for a clock
  assign link_rst = rst || select_n;

  // two zeros, own channel, two zeros, other channel
  assign word_a = {2'b00, pub_reg.chan_a, 2'b00, pub_reg.chan_b};
  assign word_b = {2'b00, pub_reg.chan_b, 2'b00, pub_reg.chan_a};

  // falling-edge count, stuck at the last edge of a long frame
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      edge_cnt_reg <= '0;
    end else if (edge_cnt_reg != `EDGE_LAST) begin
      edge_cnt_reg <= edge_cnt_reg + 1'b1;
    end
  end

  // reload at edge 1 picks up the published word for the whole frame
  // shifters; cleared state is the leading zero seen at select fall
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      shift_a_reg <= '0;
      shift_b_reg <= '0;
    end else if (edge_cnt_reg == '0) begin
      shift_a_reg <= {word_a[`FRAME_W-2:0], 1'b0};
      shift_b_reg <= {word_b[`FRAME_W-2:0], 1'b0};
    end else begin
      shift_a_reg <= {shift_a_reg[`FRAME_W-2:0], 1'b0};
      shift_b_reg <= {shift_b_reg[`FRAME_W-2:0], 1'b0};
    end
  end

  assign result_line_a = shift_a_reg[`FRAME_W-1];
  assign result_line_b = shift_b_reg[`FRAME_W-1];
  // lines float when select is high or after the 32nd edge
  assign result_line_a_oe = !select_n && (edge_cnt_reg != `EDGE_LAST);
  assign result_line_b_oe = !select_n && (edge_cnt_reg != `EDGE_LAST);

  // edge 2 and edge 10 mark the power-down window, edge 16 a finished
  // conversion; each toggles once per frame at most
  // toggles survive select rise, so short frames are never missed
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      tog_lo_reg <= 1'b0;
      tog_hi_reg <= 1'b0;
      tog_conv_reg <= 1'b0;
    end else if (!select_n) begin
      if (edge_cnt_reg == `EDGE_PD_LO - 1'b1) begin
        tog_lo_reg <= !tog_lo_reg;
      end
      if (edge_cnt_reg == `EDGE_PD_HI - 1'b1) begin
        tog_hi_reg <= !tog_hi_reg;
      end
      if (edge_cnt_reg == `EDGE_CONV - 1'b1) begin
        tog_conv_reg <= !tog_conv_reg;
      end
    end
  end

  // back to track on the rising edge after the sixteenth falling edge
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      back_track_reg <= 1'b0;
    end else if (edge_cnt_reg >= `EDGE_CONV) begin
      back_track_reg <= 1'b1;
    end
  end

  // holding only between select fall and that rising edge
  assign sampler_track = select_n || back_track_reg;

  // core domain
  logic [2:0] sel_sync_reg;
  logic [2:0] lo_sync_reg;
  logic [2:0] hi_sync_reg;
  logic [2:0] conv_sync_reg;
  logic sel_fall;
  logic sel_rise;
  logic seen_lo_reg;
  logic seen_hi_reg;
  logic seen_conv_reg;
  logic seen_lo_next;
  logic seen_hi_next;
  logic seen_conv_next;
  result_pair_t pend_reg;
  logic pend_valid_reg;
  power_mode_t mode_reg;
  logic strobe_reg;
  logic full_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [`FIFO_W-1:0] fifo_out_data;

  // three stages: two to settle, the third for edge detection
  // bit 0 feeds only bit 1; edges use bits 1 and 2
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_sync_reg <= 3'h7;
      lo_sync_reg <= 3'h0;
      hi_sync_reg <= 3'h0;
      conv_sync_reg <= 3'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], select_n};
      lo_sync_reg <= {lo_sync_reg[1:0], tog_lo_reg};
      hi_sync_reg <= {hi_sync_reg[1:0], tog_hi_reg};
      conv_sync_reg <= {conv_sync_reg[1:0], tog_conv_reg};
    end
  end

  assign sel_fall = sel_sync_reg[2] && !sel_sync_reg[1];
  assign sel_rise = !sel_sync_reg[2] && sel_sync_reg[1];

  // edge milestones reached in this frame; a toggle seen at the rise still counts
  always_comb begin
    seen_lo_next = seen_lo_reg || (lo_sync_reg[2] != lo_sync_reg[1]);
    seen_hi_next = seen_hi_reg || (hi_sync_reg[2] != hi_sync_reg[1]);
    seen_conv_next = seen_conv_reg || (conv_sync_reg[2] != conv_sync_reg[1]);
  end

  // cleared as each frame opens so milestones never leak across frames
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen_lo_reg <= 1'b0;
      seen_hi_reg <= 1'b0;
      seen_conv_reg <= 1'b0;
    end else if (sel_fall) begin
      seen_lo_reg <= 1'b0;
      seen_hi_reg <= 1'b0;
      seen_conv_reg <= 1'b0;
    end else begin
      seen_lo_reg <= seen_lo_next;
      seen_hi_reg <= seen_hi_next;
      seen_conv_reg <= seen_conv_next;
    end
  end

  // inputs frozen as the frame opens
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_reg <= '0;
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= sel_fall;
      if (sel_fall) begin
        pend_reg <= '{chan_a: ain_a, chan_b: ain_b};
      end
    end
  end

  // a rise before the second edge leaves the mode alone, so glitches on
  // select cannot power the converter up or down
  // power state decided when select goes high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= pm_normal;
    end else if (sel_rise) begin
      if (seen_hi_next) begin
        mode_reg <= pm_normal;
      end else if (seen_lo_next) begin
        case (mode_reg)
          pm_normal: mode_reg <= pm_partial;
          pm_partial: mode_reg <= pm_full;
          pm_full: mode_reg <= pm_full;
          default: mode_reg <= pm_normal;
        endcase
      end
    end
  end

  // a wake frame in power-down gives no result, so data after wake
  // comes from the frame that follows it
  // a full conversion in normal mode yields a result; the fifo may stall it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_valid_reg <= 1'b0;
    end else if (sel_rise && seen_conv_next && mode_reg == pm_normal) begin
      pend_valid_reg <= 1'b1;
    end else if (fifo_in_ready) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // drain only while no frame runs, so the link reads a still word
  assign fifo_out_ready = sel_sync_reg[1] && sel_sync_reg[2];

  result_fifo #(
    .W(`FIFO_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_data(pend_reg),
    .in_valid(pend_valid_reg),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // popped only while select is high, see the crossing notes above
  // word read out in the next frame, hence the one-sample lag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pub_reg <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      pub_reg <= fifo_out_data;
    end
  end

  // full flag one cycle late; only a stalled drain can raise it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_reg <= 1'b0;
    end else begin
      full_reg <= !fifo_in_ready;
    end
  end

  // remaining outputs straight from their flops
  assign sample_strobe = strobe_reg;
  assign power_mode = mode_reg;
  assign fifo_full = full_reg;
endmodule : dual_adc_serial_readout

// File: bench/dual_adc_props.sv
// port checker of the serial readout, bound to its top module
`include "adc_consts.svh"
module dual_adc_props
  import adc_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rst, // async reset
  input wire logic sclk, // serial clock
  input wire logic select_n, // frame select
  input wire logic result_line_a, // data a
  input wire logic result_line_a_oe, // a driven
  input wire logic result_line_b, // data b
  input wire logic result_line_b_oe, // b driven
  input wire logic sampler_track, // tracking
  input wire logic sample_strobe, // frame pulse
  input power_mode_t power_mode // power state
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt;
  logic [5:0] len;
  // edges of the open frame; select high clears it with no clock
  always_ff @(negedge sclk or posedge select_n) begin
    if (select_n) cnt <= 6'h00;
    else if (cnt != `EDGE_LAST) cnt <= cnt + 6'h01;
  end
  // length kept past the rise, since power moves on it
  always_ff @(negedge sclk) begin
    if (!select_n) len <= cnt + 6'h01;
  end
  sequence frame_open;
    $fell(select_n) ##0 power_mode == pm_normal;
  endsequence
  sequence frame_close;
    $rose(select_n);
  endsequence
  a_oe_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (select_n || cnt == `EDGE_LAST) |-> !result_line_a_oe && !result_line_b_oe)
    else $error("line driven outside frame");
  a_oe_frame: assert property (@(posedge ref_clk) disable iff (rst)
    (!select_n && cnt != `EDGE_LAST) |-> result_line_a_oe && result_line_b_oe)
    else $error("line floats inside frame");
  a_lead_zeros: assert property (@(negedge sclk) disable iff (rst || select_n)
    (power_mode == pm_normal && cnt inside {6'h00, 6'h01, 6'h10, 6'h11})
    |-> !result_line_a && !result_line_b) else $error("leading zero missing");
  a_track_edge: assert property (@(negedge sclk) disable iff (rst || select_n)
    power_mode == pm_normal |-> sampler_track == (cnt >= `EDGE_CONV))
    else $error("sampler state wrong");
  a_strobe_after: assert property (@(posedge ref_clk) disable iff (rst)
    frame_open |-> ##[1:6] sample_strobe) else $error("no sample strobe");
  a_pd_partial: assert property (@(posedge ref_clk) disable iff (rst)
    frame_close ##0 (len inside {[6'h02:6'h09]} && power_mode == pm_normal)
    |-> ##[1:6] power_mode == pm_partial) else $error("partial mode missed");
  a_pd_full: assert property (@(posedge ref_clk) disable iff (rst)
    frame_close ##0 (len inside {[6'h02:6'h09]} && power_mode == pm_partial)
    |-> ##[1:6] power_mode == pm_full) else $error("full mode missed");
  a_pd_wake: assert property (@(posedge ref_clk) disable iff (rst)
    frame_close ##0 (len >= `EDGE_PD_HI) |-> ##[1:6] power_mode == pm_normal)
    else $error("wake missed");
endmodule : dual_adc_props

bind dual_adc_serial_readout dual_adc_props dual_adc_props_i (.ref_clk, .rst, .sclk,
  .select_n, .result_line_a, .result_line_a_oe, .result_line_b, .result_line_b_oe,
  .sampler_track, .sample_strobe, .power_mode);

// File: bench/adc_host.sv
// host side of the link: frames, serial clock and bit capture
module adc_host (
  output logic sclk, // still high between frames
  output logic select_n, // frame select
  input wire logic line_a, // wire level a
  input wire logic line_b, // wire level b
  output logic [31:0] cap_a, // bits taken from a
  output logic [31:0] cap_b // bits taken from b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b1;
    select_n = 1'b1;
  end
  // frame of n falling edges, 64 ns period, bit taken just before each fall
  task automatic frame(input int n);
    cap_a = 32'h0;
    cap_b = 32'h0;
    select_n = 1'b0;
    #37; // edge one lands well after the fall
    for (int k = 0; k < n; k++) begin
      cap_a = {cap_a[30:0], line_a};
      cap_b = {cap_b[30:0], line_b};
      sclk = 1'b0;
      #32;
      sclk = 1'b1;
      #32;
    end
    select_n = 1'b1;
  endtask : frame
endmodule : adc_host

// File: bench/test_dual_adc_serial_readout.sv
// testbench of the dual converter serial readout
`include "adc_consts.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module test_dual_adc_serial_readout
  import adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [`RES_W-1:0] ain_a = 14'h0000;
  logic [`RES_W-1:0] ain_b = 14'h0000;
  logic sclk, select_n, result_line_a, result_line_a_oe, result_line_b, result_line_b_oe;
  logic sampler_track, sample_strobe, fifo_full, wire_a, wire_b;
  logic [31:0] cap_a, cap_b;
  power_mode_t power_mode;
  int n_fail = 0;
  int comparisons = 0;
  always #4 ref_clk = ~ref_clk;
  // released line shows the inverse, no pull on it
  assign wire_a = result_line_a_oe ? result_line_a : ~result_line_a;
  assign wire_b = result_line_b_oe ? result_line_b : ~result_line_b;
  dual_adc_serial_readout dual_adc_serial_readout_i (.ref_clk, .rst, .ain_a, .ain_b, .sclk,
    .select_n, .result_line_a, .result_line_a_oe, .result_line_b, .result_line_b_oe,
    .sampler_track, .sample_strobe, .power_mode, .fifo_full);
  adc_host adc_host_i (.sclk, .select_n, .line_a(wire_a), .line_b(wire_b), .cap_a, .cap_b);
  // one frame with fresh levels, then a gap so the core publishes
  task automatic run(input int n, input logic [13:0] a, input logic [13:0] b);
    @(posedge ref_clk);
    #1;
    ain_a = a;
    ain_b = b;
    adc_host_i.frame(n);
    repeat (8) @(posedge ref_clk);
  endtask : run
  // one frame late, msb first, halves swapped on a long frame
  task automatic lag_test;
    run(16, 14'h3fff, 14'h0000);
    run(16, 14'h2a5c, 14'h15a3);
    `CHK(cap_a, 32'h00003fff)
    `CHK(cap_b, 32'h00000000)
    run(32, 14'h0001, 14'h2000);
    `CHK(cap_a, {2'b00, 14'h2a5c, 2'b00, 14'h15a3})
    `CHK(cap_b, {2'b00, 14'h15a3, 2'b00, 14'h2a5c})
    run(16, 14'h0000, 14'h0000);
    `CHK(cap_a, 32'h00000001)
    `CHK(cap_b, 32'h00002000)
    `CHK(fifo_full, 1'b0)
    $display("lag test done");
  endtask : lag_test
  // short frames step the power state, long ones wake it, edges 2 and 10 at the brink
  task automatic power_test;
    int lens [8] = '{1, 5, 5, 12, 9, 10, 2, 16};
    power_mode_t want [8] = '{pm_normal, pm_partial, pm_full, pm_normal,
      pm_partial, pm_normal, pm_partial, pm_normal};
    for (int i = 0; i < 8; i++) begin
      run(lens[i], 14'h0abc, 14'h1def);
      `CHK(power_mode, want[i])
    end
    $display("power test done");
  endtask : power_test
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    lag_test();
    power_test();
    report_and_stop();
  end
endmodule : test_dual_adc_serial_readout
